// >>> scr_consts.svh
`ifndef SCR_CONSTS_SVH
`define SCR_CONSTS_SVH

// ************************************************
// register offsets and address width
// ************************************************
`define SCR_ADDR_W 11
`define SCR_OFS_CTRL 11'h000
`define SCR_OFS_IDIRQ 11'h004
`define SCR_UNMAPPED_RD 32'h0000_0000

// ************************************************
// control register set/clear field positions
// ************************************************
`define SCR_LOW_SET_LSB 0
`define SCR_LOW_CLR_LSB 8
`define SCR_RSV_SET_BIT 16
`define SCR_RSV_CLR_BIT 24
`define SCR_IEN_SET_LSB 20
`define SCR_IEN_CLR_LSB 28

// ************************************************
// status view field positions
// ************************************************
`define SCR_ST_LOW_LSB 0
`define SCR_ST_PULSER_BIT 13
`define SCR_ST_GOVF_BIT 14
`define SCR_ST_GCE_BIT 15
`define SCR_ST_RSV_BIT 16
`define SCR_ST_IEN_LSB 20
`define SCR_ST_INT_IRQ_BIT 26
`define SCR_ST_EXT_IRQ_BIT 27
`define SCR_ST_SRC_LSB 28

// ************************************************
// identity and interrupt control fields
// ************************************************
`define SCR_ID_MOD_LSB 16
`define SCR_ID_VER_LSB 12
`define SCR_IRQ_EN_BIT 11
`define SCR_IRQ_LVL_LSB 8
`define SCR_IRQ_VEC_LSB 0
`define SCR_IRQ_CTL_W 12

// ************************************************
// reset values
// ************************************************
`define SCR_JK_RST 12'h000
`define SCR_IRQ_CTL_RST 12'h000
`define SCR_LVL_NONE 3'h0

`endif

// >>> scr_pkg.sv
`include "scr_consts.svh"

package scr_pkg;

    // ************************************************
    // register port
    // ************************************************
    typedef struct packed {
        logic stb;
        logic we;
        logic [`SCR_ADDR_W-1:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } scr_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } scr_rsp_t;

    // ************************************************
    // interrupt acknowledge port
    // ************************************************
    typedef struct packed {
        logic stb;
        logic [2:0] level;
    } scr_iack_req_t;

    typedef struct packed {
        logic ack;
        logic [7:0] vector;
    } scr_iack_rsp_t;

    // ************************************************
    // module settings driven to the rest of the scaler
    // ************************************************
    typedef struct packed {
        logic user_led;
        logic test_pulse_en;
        logic input_test_en;
        logic bcast_en;
        logic bcast_hs_ctl;
        logic [1:0] input_mode;
    } scr_ctrl_t;

    // ************************************************
    // bus interrupter states, gray along idle-req-acked
    // ************************************************
    typedef enum logic [1:0] {
        SCR_IRQ_IDLE = 2'b00,
        SCR_IRQ_REQ = 2'b01,
        SCR_IRQ_ACKED = 2'b11
    } scr_irq_state_t;

    typedef struct packed {
        logic [`SCR_IRQ_CTL_W-1:0] irq_ctl;
        scr_irq_state_t irq_state;
        logic rsp_ack;
        logic [31:0] rsp_rdata;
        logic iack_ack;
        logic [7:0] iack_vec;
    } scr_state_t;

endpackage : scr_pkg

// >>> scr_jk_bank.sv
`timescale 1ns/1ps

module scr_jk_bank #(
    parameter int N = 12,
    parameter logic [N-1:0] RST = '0
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic sync_clr,
    input wire logic [N-1:0] set_v,
    input wire logic [N-1:0] clr_v,
    output logic [N-1:0] q
);

    typedef struct packed {
        logic [N-1:0] q;
    } scr_jk_st_t;

    scr_jk_st_t st_ff;
    scr_jk_st_t nxt_st;

    if (N < 1) begin : g_chk
        $error("scr_jk_bank needs at least one bit");
    end

    // ************************************************
    // set wins alone, clear wins alone, both toggles
    // ************************************************
    always_comb begin
        nxt_st = st_ff;
        if (sync_clr) begin
            nxt_st.q = RST;
        end else begin
            nxt_st.q = (set_v & ~st_ff.q) | (~clr_v & st_ff.q);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '{q: RST};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.q;

endmodule : scr_jk_bank

// >>> scr_regs.sv
`timescale 1ns/1ps

module scr_regs
    import scr_pkg::*;
#(
    parameter logic [15:0] MODULE_ID = 16'h1234,
    parameter logic [3:0] VERSION = 4'h1
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic key_reset,
    input scr_req_t reg_req,
    output scr_rsp_t reg_rsp,
    input scr_iack_req_t iack_req,
    output scr_iack_rsp_t iack_rsp,
    input wire logic ovf_src,
    input wire logic shadow_src,
    input wire logic count_en_st,
    input wire logic gen_ovf_st,
    input wire logic pulser_st,
    output scr_ctrl_t ctrl,
    output logic irq_req,
    output logic [2:0] irq_level
);

    // ************************************************
    // elaboration checks
    // ************************************************
    // module number is four decimal digits, each nibble 0..9
    if ((MODULE_ID[15:12] > 4'h9) || (MODULE_ID[11:8] > 4'h9) ||
        (MODULE_ID[7:4] > 4'h9) || (MODULE_ID[3:0] > 4'h9)) begin : g_chk_bcd
        $error("MODULE_ID must hold four decimal digits");
    end

    // header layout has to match the packing done below
    if (`SCR_IRQ_CTL_W != 12) begin : g_chk_ctl_w
        $error("interrupt control field must be 12 bits wide");
    end
    if (`SCR_ID_VER_LSB != `SCR_IRQ_CTL_W) begin : g_chk_ver_pos
        $error("version field must sit above the control bits");
    end
    if (`SCR_ID_MOD_LSB != `SCR_ID_VER_LSB + 4) begin : g_chk_mod_pos
        $error("module number must sit above the version");
    end
    if (`SCR_LOW_CLR_LSB != `SCR_LOW_SET_LSB + 8) begin : g_chk_low_pos
        $error("low clear bits must sit one byte above the set bits");
    end
    if (`SCR_IEN_CLR_LSB != `SCR_IEN_SET_LSB + 8) begin : g_chk_ien_pos
        $error("source disable bits must sit one byte above the enables");
    end

    // ************************************************
    // jk bank layout
    // ************************************************
    // 0 led, 1 test irq, 2 mode0, 3 mode1, 4 pulses, 5 test mode,
    // 6 broadcast, 7 handshake ctl, 8 reserved, 11:9 source enables
    localparam int JK_N = 12;
    localparam int JK_RSV = 8;
    localparam int JK_IEN = 9;
    localparam int JK_LED = 0;
    localparam int JK_TIRQ = 1;
    localparam int JK_MODE = 2;
    localparam int JK_PULSE = 4;
    localparam int JK_ITEST = 5;
    localparam int JK_BCAST = 6;
    localparam int JK_HSCTL = 7;
    if (JK_IEN + 3 != JK_N) begin : g_chk_jk_n
        $error("source enables must fill the top of the bank");
    end

    scr_state_t st_ff;
    scr_state_t nxt_st;

    logic [JK_N-1:0] jk_q;
    logic [JK_N-1:0] jk_set;
    logic [JK_N-1:0] jk_clr;
    logic [31:0] wmask;
    logic [31:0] wbits;
    logic wr_ctrl;
    logic wr_idirq;
    logic hit_ctrl;
    logic hit_idirq;
    logic [2:0] src_state;
    logic [2:0] src_en;
    logic int_irq;
    logic req_allowed;
    logic irq_glob_en;
    logic irq_lvl_ok;
    logic irq_on_bus;
    logic iack_hit;
    logic [31:0] rd_view;
    logic [31:0] status_view;
    logic [31:0] idirq_view;

    // ************************************************
    // address decode and byte lanes
    // ************************************************
    assign hit_ctrl = (reg_req.addr == `SCR_OFS_CTRL);
    assign hit_idirq = (reg_req.addr == `SCR_OFS_IDIRQ);
    assign wr_ctrl = reg_req.stb && reg_req.we && hit_ctrl;
    assign wr_idirq = reg_req.stb && reg_req.we && hit_idirq;

    // d16 writes only touch their enabled lanes
    assign wmask = {{8{reg_req.be[3]}}, {8{reg_req.be[2]}},
                    {8{reg_req.be[1]}}, {8{reg_req.be[0]}}};
    assign wbits = reg_req.wdata & wmask;

    // ************************************************
    // control register set/clear decode
    // ************************************************
    always_comb begin
        jk_set = '0;
        jk_clr = '0;
        if (wr_ctrl) begin
            jk_set[7:0] = wbits[`SCR_LOW_SET_LSB +: 8];
            jk_clr[7:0] = wbits[`SCR_LOW_CLR_LSB +: 8];
            jk_set[JK_RSV] = wbits[`SCR_RSV_SET_BIT];
            jk_clr[JK_RSV] = wbits[`SCR_RSV_CLR_BIT];
            jk_set[JK_IEN +: 3] = wbits[`SCR_IEN_SET_LSB +: 3];
            jk_clr[JK_IEN +: 3] = wbits[`SCR_IEN_CLR_LSB +: 3];
        end
    end

    // all function bits live in one jk bank, cleared by either reset
    scr_jk_bank #(
        .N(JK_N),
        .RST(`SCR_JK_RST)
    ) u_jk (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .sync_clr(key_reset),
        .set_v(jk_set),
        .clr_v(jk_clr),
        .q(jk_q)
    );

    // ************************************************
    // interrupt sources
    // ************************************************
    // source 2 is the software test condition held in the bank
    assign src_state = {jk_q[JK_TIRQ], shadow_src, ovf_src};
    assign src_en = jk_q[JK_IEN +: 3];
    assign int_irq = |(src_state & src_en);
    assign irq_glob_en = st_ff.irq_ctl[`SCR_IRQ_EN_BIT];
    // level zero is not a bus level, so it never requests
    assign irq_lvl_ok = (irq_level != `SCR_LVL_NONE);
    assign req_allowed = int_irq && irq_glob_en && irq_lvl_ok;
    // a level match only counts while our request is on the bus
    assign irq_on_bus = (st_ff.irq_state == SCR_IRQ_REQ);
    assign iack_hit = iack_req.stb && (iack_req.level == irq_level);

    // ************************************************
    // read views
    // ************************************************
    always_comb begin
        status_view = '0;
        status_view[`SCR_ST_LOW_LSB +: 8] = jk_q[7:0];
        status_view[`SCR_ST_PULSER_BIT] = pulser_st;
        status_view[`SCR_ST_GOVF_BIT] = gen_ovf_st;
        status_view[`SCR_ST_GCE_BIT] = count_en_st;
        status_view[`SCR_ST_RSV_BIT] = jk_q[JK_RSV];
        status_view[`SCR_ST_IEN_LSB +: 3] = src_en;
        status_view[`SCR_ST_INT_IRQ_BIT] = int_irq;
        status_view[`SCR_ST_EXT_IRQ_BIT] = irq_on_bus;
        status_view[`SCR_ST_SRC_LSB +: 3] = src_state;
    end

    always_comb begin
        idirq_view = '0;
        idirq_view[`SCR_ID_MOD_LSB +: 16] = MODULE_ID;
        idirq_view[`SCR_ID_VER_LSB +: 4] = VERSION;
        idirq_view[`SCR_IRQ_CTL_W-1:0] = st_ff.irq_ctl;
    end

    // unmapped offsets still answer, with zeros
    always_comb begin
        if (hit_ctrl) begin
            rd_view = status_view;
        end else if (hit_idirq) begin
            rd_view = idirq_view;
        end else begin
            rd_view = `SCR_UNMAPPED_RD;
        end
    end

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rsp_ack = 1'b0;
        nxt_st.iack_ack = 1'b0;

        // register answer, one cycle after the strobe
        if (reg_req.stb) begin
            nxt_st.rsp_ack = 1'b1;
            // writes leave the last read answer in place
            if (!reg_req.we) begin
                nxt_st.rsp_rdata = rd_view;
            end
        end

        // only the low 12 bits are storage, identity is constant
        if (wr_idirq) begin
            nxt_st.irq_ctl = (st_ff.irq_ctl & ~wmask[`SCR_IRQ_CTL_W-1:0]) |
                             wbits[`SCR_IRQ_CTL_W-1:0];
        end

        // bus interrupter
        case (st_ff.irq_state)
            SCR_IRQ_IDLE: begin
                if (req_allowed) begin
                    nxt_st.irq_state = SCR_IRQ_REQ;
                end
            end
            SCR_IRQ_REQ: begin
                if (iack_hit) begin
                    // a request already on the bus is answered even if
                    // its condition falls in the same cycle
                    nxt_st.irq_state = SCR_IRQ_ACKED;
                    nxt_st.iack_ack = 1'b1;
                    nxt_st.iack_vec = st_ff.irq_ctl[`SCR_IRQ_VEC_LSB +: 8];
                end else if (!req_allowed) begin
                    // withdrawn before anyone answered
                    nxt_st.irq_state = SCR_IRQ_IDLE;
                end
            end
            SCR_IRQ_ACKED: begin
                // stays released until the condition goes away,
                // otherwise one stuck source would storm the bus
                if (!req_allowed) begin
                    nxt_st.irq_state = SCR_IRQ_IDLE;
                end
            end
            default: begin
                nxt_st.irq_state = SCR_IRQ_IDLE;
            end
        endcase

        if (key_reset) begin
            nxt_st.irq_ctl = `SCR_IRQ_CTL_RST;
            nxt_st.irq_state = SCR_IRQ_IDLE;
        end
    end

    // ************************************************
    // state register
    // ************************************************
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '{irq_ctl: `SCR_IRQ_CTL_RST,
                       irq_state: SCR_IRQ_IDLE,
                       rsp_ack: 1'b0,
                       rsp_rdata: 32'h0000_0000,
                       iack_ack: 1'b0,
                       iack_vec: 8'h00};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    assign reg_rsp.ack = st_ff.rsp_ack;
    assign reg_rsp.rdata = st_ff.rsp_rdata;
    assign iack_rsp.ack = st_ff.iack_ack;
    assign iack_rsp.vector = st_ff.iack_vec;
    assign irq_req = irq_on_bus;
    assign irq_level = st_ff.irq_ctl[`SCR_IRQ_LVL_LSB +: 3];

    assign ctrl.user_led = jk_q[JK_LED];
    assign ctrl.input_mode = jk_q[JK_MODE +: 2];
    assign ctrl.test_pulse_en = jk_q[JK_PULSE];
    assign ctrl.input_test_en = jk_q[JK_ITEST];
    assign ctrl.bcast_en = jk_q[JK_BCAST];
    assign ctrl.bcast_hs_ctl = jk_q[JK_HSCTL];

endmodule : scr_regs

// >>> scr_regs_properties.sv
`timescale 1ns/1ps

module scr_regs_properties
    import scr_pkg::*;
#(
    parameter logic [15:0] MODULE_ID = 16'h1234,
    parameter logic [3:0] VERSION = 4'h1
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic key_reset,
    input scr_req_t reg_req,
    input scr_rsp_t reg_rsp,
    input scr_iack_req_t iack_req,
    input scr_iack_rsp_t iack_rsp,
    input wire logic ovf_src,
    input wire logic shadow_src,
    input wire logic count_en_st,
    input wire logic gen_ovf_st,
    input wire logic pulser_st,
    input scr_ctrl_t ctrl,
    input wire logic irq_req,
    input wire logic [2:0] irq_level
);
    // ****************
    // bus write decode
    // ****************
    logic wr0;
    logic wr4;
    // key reset wins over a write in the same cycle
    assign wr0 = reg_req.stb && reg_req.we && reg_req.addr == 11'h000 && !key_reset;
    assign wr4 = reg_req.stb && reg_req.we && reg_req.addr == 11'h004 && !key_reset;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_ack_every_access: assert property (reg_req.stb |=> reg_rsp.ack)
        else $error("access not acknowledged next cycle");
    a_led_on: assert property (wr0 && reg_req.be[0] && reg_req.wdata[0]
        && !(reg_req.be[1] && reg_req.wdata[8]) |=> ctrl.user_led)
        else $error("user indicator not lit");
    a_led_off: assert property (wr0 && reg_req.be[1] && reg_req.wdata[8]
        && !reg_req.wdata[0] |=> !ctrl.user_led)
        else $error("user indicator not extinguished");
    a_zero_write_keeps: assert property (wr0 && reg_req.wdata == 32'h0 |=> $stable(ctrl))
        else $error("zero write changed settings");
    a_mode_hi_set: assert property (wr0 && reg_req.be[0] && reg_req.wdata[3]
        && !(reg_req.be[1] && reg_req.wdata[11]) |=> ctrl.input_mode[1])
        else $error("input mode upper bit not set");
    a_bcast_clear: assert property (wr0 && reg_req.be[1] && reg_req.wdata[14]
        && !(reg_req.be[0] && reg_req.wdata[6]) |=> !ctrl.bcast_en)
        else $error("broadcast mode not cleared");
    a_ident_fixed: assert property (reg_req.stb && !reg_req.we && reg_req.addr == 11'h004
        |=> reg_rsp.rdata[31:12] == {MODULE_ID, VERSION})
        else $error("identity field wrong");
    a_level_written: assert property (wr4 && reg_req.be[1]
        |=> irq_level == $past(reg_req.wdata[10:8]))
        else $error("interrupt level not stored");
    a_ack_releases: assert property (iack_req.stb && irq_req && iack_req.level == irq_level
        |=> iack_rsp.ack && !irq_req)
        else $error("acknowledge did not release request");
    a_no_ack_mismatch: assert property (iack_req.stb && iack_req.level != irq_level
        |=> !iack_rsp.ack)
        else $error("acknowledge at foreign level");
endmodule : scr_regs_properties

bind scr_regs scr_regs_properties #(.MODULE_ID(MODULE_ID), .VERSION(VERSION)) i_scr_regs_properties (
    .sys_clk(sys_clk), .resetn(resetn), .key_reset(key_reset), .reg_req(reg_req),
    .reg_rsp(reg_rsp), .iack_req(iack_req), .iack_rsp(iack_rsp), .ovf_src(ovf_src),
    .shadow_src(shadow_src), .count_en_st(count_en_st), .gen_ovf_st(gen_ovf_st),
    .pulser_st(pulser_st), .ctrl(ctrl), .irq_req(irq_req), .irq_level(irq_level));

// >>> scr_host.sv
`timescale 1ns/1ps

module scr_host
    import scr_pkg::*;
(
    input wire logic sys_clk,
    output scr_req_t reg_req,
    input scr_rsp_t reg_rsp,
    output scr_iack_req_t iack_req,
    input scr_iack_rsp_t iack_rsp
);
    initial begin
        reg_req = '0;
        iack_req = '0;
    end

    // strobe is a one-cycle pulse; answer is looked for after it drops, for up to four cycles
    task automatic access(input logic we, input logic [10:0] a, input logic [31:0] wd,
        input logic [3:0] be, output logic [31:0] rd, output bit ok);
        ok = 1'b0;
        @(negedge sys_clk);
        reg_req = '{stb: 1'b1, we: we, addr: a, be: be, wdata: wd};
        for (int i = 0; i < 4 && !ok; i++) begin
            @(negedge sys_clk);
            reg_req.stb = 1'b0;
            // released data lines must not keep the old value
            reg_req.wdata = ~wd;
            ok = (reg_rsp.ack === 1'b1);
        end
        rd = reg_rsp.rdata;
    endtask : access

    task automatic iack(input logic [2:0] lvl, output logic ack, output logic [7:0] vec);
        @(negedge sys_clk);
        iack_req = '{stb: 1'b1, level: lvl};
        @(negedge sys_clk);
        iack_req.stb = 1'b0;
        ack = iack_rsp.ack;
        vec = iack_rsp.vector;
    endtask : iack
endmodule : scr_host

// >>> scr_regs_tb.sv
`timescale 1ns/1ps

module scr_regs_tb;
    import scr_pkg::*;
    // arbitrary identity values
    localparam logic [15:0] MID = 16'h4321;
    localparam logic [3:0] VER = 4'h5;
    logic sys_clk, resetn, key_reset, ovf_src, shadow_src, count_en_st, gen_ovf_st, pulser_st;
    logic irq_req;
    logic [2:0] irq_level;
    scr_req_t reg_req;
    scr_rsp_t reg_rsp;
    scr_iack_req_t iack_req;
    scr_iack_rsp_t iack_rsp;
    scr_ctrl_t ctrl;
    int err_total = 0;
    int checks = 0;

    scr_regs #(.MODULE_ID(MID), .VERSION(VER)) i_scr_regs (.sys_clk(sys_clk), .resetn(resetn),
        .key_reset(key_reset), .reg_req(reg_req), .reg_rsp(reg_rsp), .iack_req(iack_req),
        .iack_rsp(iack_rsp), .ovf_src(ovf_src), .shadow_src(shadow_src),
        .count_en_st(count_en_st), .gen_ovf_st(gen_ovf_st), .pulser_st(pulser_st), .ctrl(ctrl),
        .irq_req(irq_req), .irq_level(irq_level));
    scr_host i_scr_host (.sys_clk(sys_clk), .reg_req(reg_req), .reg_rsp(reg_rsp),
        .iack_req(iack_req), .iack_rsp(iack_rsp));

    // ****************
    // helpers
    // ****************
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic acc(input logic we, input logic [10:0] a, input logic [31:0] d,
        input logic [3:0] be, output logic [31:0] r);
        bit ok;
        i_scr_host.access(we, a, d, be, r, ok);
        if (!ok) begin
            err_total++;
            $display("MISMATCH reg ack expected 1 seen 0");
            summarize();
        end
    endtask : acc

    // ****************
    // scenarios
    // ****************
    task automatic t_jk();
        int sb[11] = '{0, 1, 2, 3, 4, 5, 6, 7, 20, 21, 22};
        logic [31:0] r, exp;
        // packed position of each function in ctrl, -1 where none
        int cb[11] = '{6, -1, 0, 1, 5, 4, 3, 2, -1, -1, -1};
        logic [6:0] ec;
        for (int i = 0; i < 11; i++) begin
            exp = 32'h1 << sb[i];
            if (sb[i] == 1) exp |= 32'h4000_0000;
            acc(1'b1, 11'h000, 32'h1 << sb[i], 4'hF, r);
            acc(1'b0, 11'h000, 32'h0, 4'hF, r);
            check("set", exp, r);
            ec = (cb[i] < 0) ? 7'h00 : 7'h01 << cb[i];
            check("ctrl set", {25'h0, ec}, {25'h0, ctrl});
            acc(1'b1, 11'h000, 32'h0, 4'hF, r);
            acc(1'b0, 11'h000, 32'h0, 4'hF, r);
            check("hold", exp, r);
            acc(1'b1, 11'h000, 32'h1 << (sb[i] + 8), 4'hF, r);
            acc(1'b0, 11'h000, 32'h0, 4'hF, r);
            check("clear", 32'h0, r);
            check("ctrl clear", 32'h0, {25'h0, ctrl});
        end
    endtask : t_jk

    task automatic t_irq();
        logic [31:0] r;
        logic a;
        logic [7:0] v;
        acc(1'b1, 11'h004, 32'hFFFF_FABC, 4'hF, r);
        acc(1'b0, 11'h004, 32'h0, 4'hF, r);
        check("idirq", {MID, VER, 12'hABC}, r);
        check("level", 32'h2, {29'h0, irq_level});
        acc(1'b1, 11'h000, 32'h0010_0000, 4'hF, r);
        ovf_src = 1'b1;
        for (int i = 0; i < 8 && irq_req !== 1'b1; i++) @(negedge sys_clk);
        if (irq_req !== 1'b1) begin
            err_total++;
            $display("MISMATCH irq_req expected 1 seen %b", irq_req);
            summarize();
        end
        acc(1'b0, 11'h000, 32'h0, 4'hF, r);
        check("pending", 32'h1C10_0000, r);
        i_scr_host.iack(3'h3, a, v);
        check("foreign ack", 32'h0, {31'h0, a});
        i_scr_host.iack(3'h2, a, v);
        check("ack", 32'h1, {31'h0, a});
        check("vector", 32'hBC, {24'h0, v});
        check("released", 32'h0, {31'h0, irq_req});
        ovf_src = 1'b0;
        acc(1'b1, 11'h004, 32'h0000_02BC, 4'hF, r);
        ovf_src = 1'b1;
        repeat (3) @(negedge sys_clk);
        check("gated", 32'h0, {31'h0, irq_req});
        acc(1'b0, 11'h000, 32'h0, 4'hF, r);
        check("internal", 32'h1410_0000, r);
        acc(1'b1, 11'h000, 32'h1000_0000, 4'hF, r);
        acc(1'b0, 11'h000, 32'h0, 4'hF, r);
        check("disabled src", 32'h1000_0000, r);
        ovf_src = 1'b0;
        acc(1'b1, 11'h000, 32'h0020_0000, 4'hF, r);
        shadow_src = 1'b1;
        acc(1'b0, 11'h000, 32'h0, 4'hF, r);
        check("shadow src", 32'h2420_0000, r);
        shadow_src = 1'b0;
        acc(1'b1, 11'h000, 32'h2000_0000, 4'hF, r);
    endtask : t_irq

    task automatic t_key();
        logic [31:0] r;
        {count_en_st, gen_ovf_st, pulser_st} = 3'b111;
        // clear lane disabled, so only the set takes effect
        acc(1'b1, 11'h000, 32'h0000_0101, 4'h1, r);
        acc(1'b0, 11'h000, 32'h0, 4'hF, r);
        check("lane", 32'h0000_E001, r);
        acc(1'b1, 11'h004, 32'h0000_0FFF, 4'hF, r);
        key_reset = 1'b1;
        @(negedge sys_clk);
        key_reset = 1'b0;
        acc(1'b0, 11'h000, 32'h0, 4'hF, r);
        check("key status", 32'h0000_E000, r);
        acc(1'b0, 11'h004, 32'h0, 4'hF, r);
        check("key idirq", {MID, VER, 12'h000}, r);
        acc(1'b0, 11'h008, 32'h0, 4'hF, r);
        check("unmapped", 32'h0, r);
        {count_en_st, gen_ovf_st, pulser_st} = 3'b000;
    endtask : t_key

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    initial begin
        logic [31:0] r;
        {resetn, key_reset, ovf_src, shadow_src, count_en_st, gen_ovf_st, pulser_st} = '0;
        repeat (8) @(negedge sys_clk);
        resetn = 1'b1;
        acc(1'b0, 11'h000, 32'h0, 4'hF, r);
        check("reset status", 32'h0, r);
        acc(1'b0, 11'h004, 32'h0, 4'hF, r);
        check("reset idirq", {MID, VER, 12'h000}, r);
        t_jk();
        t_irq();
        t_key();
        summarize();
    end
endmodule : scr_regs_tb
